// ==== design/classic_serial_port_zero.sv ====
`timescale 1ns/100ps
`include "serial_port_defs.svh"

// Operation
// RULE1 - Transmitter and receiver run concurrently; in mode 0 receive starts only with transmit idle and a buffer write ends it
// RULE2 - Receive holding register separate from shifter
// RULE3 - Control bits 7:6 choose mode
// RULE4 - Mode 0 shifts LSB first, clk/12
// RULE5 - Mode 0 receive needs done clear, enable
// RULE6 - Mode 1 timer rate divided 32/16
// RULE7 - Mode 3 rate same as mode 1
// RULE8 - Receive done set, software clears
// RULE9 - Transmit done set, software clears
// RULE10 - Interrupt when flag and enable set
// RULE11 - Software flag writes act like hardware
// RULE12 - Ninth received bit or stop bit
// RULE13 - Written ninth bit sent in modes 2/3
// RULE14 - Multiprocessor filter drops ninth bit zero
// RULE15 - Master marks addresses with ninth bit
// RULE16 - Buffer write starts transmission
// RULE17 - Buffer read returns receive holding register
// RULE18 - Mode 1 frame start, eight, stop
// RULE19 - Modes 2/3 frame adds ninth bit
// RULE20 - Mode 2 rate clk/64 or clk/32
// RULE21 - Receive only while enable set
// RULE22 - Start edge, midbit check, centre sampling
// RULE23 - Partner matches format, rate, shift clock

module classic_serial_port_zero
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM register slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Timer rate sources
	input wire logic t1_overflow,
	input wire logic t2_overflow,
	input wire logic tx_rate_from_t2,
	input wire logic rx_rate_from_t2,
	// Serial pins
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe_n,
	output logic serial_out_pin,
	// Interrupt request
	output logic serial_irq,
	output logic serial_irq_priority
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic wait_q; // Bus wait state
	logic [31:0] rdata_q; // Captured read data
	logic [7:0] ctrl_q; // Serial control register
	logic [7:0] power_q; // Power control register
	logic [7:0] ie_q; // Interrupt enable register
	logic [7:0] ip_q; // Interrupt priority register
	logic [7:0] rx_hold_q; // Receive holding register
	logic [7:0] rd_mux; // Selected read byte
	logic wr_fire; // Write takes effect this edge
	logic wr_ctrl; // Control register write
	logic wr_buf; // Buffer register write
	logic [7:0] wbyte; // Low write lane
	serial_port_pkg::mode_t mode; // Current mode
	serial_port_pkg::tx_state_t tx_state_q; // Transmit state
	serial_port_pkg::rx_state_t rx_state_q; // Receive state
	logic [10:0] tx_frame_q; // Transmit shifter, LSB goes out
	logic [3:0] tx_ovs_q; // Transmit oversample count
	logic [3:0] tx_bit_q; // Transmit bit index
	logic [3:0] tx_last; // Last transmit bit index
	logic tx_done; // Transmit complete pulse
	logic [7:0] rx_shift_q; // Receive shifter
	logic rx_ninth_q; // Captured ninth bit
	logic [3:0] rx_ovs_q; // Receive oversample count
	logic [3:0] rx_bit_q; // Receive bit index
	logic [3:0] rx_last; // Last receive bit index
	logic rx_prev_q; // Line value one clock ago
	logic rx_fall; // Start edge seen
	logic rx_sample; // Async bit centre this clock
	logic rx_ninth_val; // Ninth bit presented at load
	logic rx_load; // Receive complete, accepted
	logic rx_load_async; // Async frame complete, last bit sampled
	logic tx_tick; // Transmit sixteen-times tick
	logic rx_tick; // Receive sixteen-times tick
	logic half_tick; // Mode 0 half period tick
	logic sclk_q; // Mode 0 shift clock
	logic [3:0] half_q; // Mode 0 half period index
	logic sync_act; // Mode 0 transfer running
	logic sync_start; // Mode 0 transfer begins
	logic sync_rise; // Shift clock rising
	logic sync_fall; // Shift clock falling
	logic sync_end; // Mode 0 transfer ends
	logic rx_sync_go; // Mode 0 receive begins
	logic out_pin_q; // Transmit pin flop
	logic data_out_q; // Data pin drive value
	logic data_oe_n_q; // Data pin enable, low drives
	logic irq_q; // Interrupt request flop
	logic pri_q; // Interrupt priority flop

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	assign wbyte = writedata[7:0];
	assign wr_fire = write & ~wait_q & byteenable[0];
	assign wr_ctrl = wr_fire && (address == `ADDR_SERIAL_CONTROL);
	assign wr_buf = wr_fire && (address == `ADDR_SERIAL_BUFFER);

	// One wait cycle per access, raised again after completion
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			wait_q <= 1'b1;
		else if ((read || write) && wait_q)
			wait_q <= 1'b0;
		else
			wait_q <= 1'b1;
	end

	// Read selection; unmapped words read zero
	always_comb
	begin
		case (address)
			`ADDR_SERIAL_CONTROL: rd_mux = ctrl_q;
			// RULE17 - read receive holding
			`ADDR_SERIAL_BUFFER: rd_mux = rx_hold_q;
			`ADDR_POWER_CONTROL: rd_mux = power_q;
			`ADDR_IRQ_ENABLE: rd_mux = ie_q;
			`ADDR_IRQ_PRIORITY: rd_mux = ip_q;
			default: rd_mux = `RESET_BYTE;
		endcase
	end

	// Data captured in the wait cycle, stands at the completing edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= `RESET_WORD;
		else if (read && wait_q)
			rdata_q <= {24'h00_0000, rd_mux};
	end

	// Plain storage registers; only bit 7, 4 and 4 steer this block
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			power_q <= `RESET_BYTE;
			ie_q <= `RESET_BYTE;
			ip_q <= `RESET_BYTE;
		end
		else if (wr_fire)
		begin
			if (address == `ADDR_POWER_CONTROL)
				power_q <= wbyte;
			if (address == `ADDR_IRQ_ENABLE)
				ie_q <= wbyte;
			if (address == `ADDR_IRQ_PRIORITY)
				ip_q <= wbyte;
		end
	end

	// Control register; hardware sets are written last so they win
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ctrl_q <= `RESET_BYTE;
		else
		begin
			// RULE11 - software flag writes
			if (wr_ctrl)
				ctrl_q <= wbyte;
			// RULE12 - capture ninth bit
			if (rx_load && rx_load_async)
				ctrl_q[`SC_RX_NINTH] <= rx_ninth_val;
			// RULE8 - set receive done
			if (rx_load)
				ctrl_q[`SC_RX_DONE] <= 1'b1;
			// RULE9 - set transmit done
			if (tx_done)
				ctrl_q[`SC_TX_DONE] <= 1'b1;
		end
	end

	// RULE3 - mode from bits 7:6
	assign mode = serial_port_pkg::mode_t'(ctrl_q[`SC_MODE_HIGH:`SC_MODE_LOW]);

	// ------------------------------------------------------------
	// Rate generation
	// ------------------------------------------------------------
	serial_rate_gen u_rate
	(
		.clk(clk),
		.nrst(nrst),
		.mode(mode),
		.baud_doubler(power_q[`PC_BAUD_DOUBLER]),
		.tx_from_t2(tx_rate_from_t2),
		.rx_from_t2(rx_rate_from_t2),
		.t1_overflow(t1_overflow),
		.t2_overflow(t2_overflow),
		.shift_restart(sync_start),
		.tx_tick(tx_tick),
		.rx_tick(rx_tick),
		.shift_half_tick(half_tick)
	);

	// ------------------------------------------------------------
	// Mode 0 shift clock
	// ------------------------------------------------------------
	assign sync_act = (tx_state_q == serial_port_pkg::TX_SYNC) ||
		(rx_state_q == serial_port_pkg::RX_SYNC);
	assign rx_sync_go = (rx_state_q == serial_port_pkg::RX_IDLE) &&
		(mode == serial_port_pkg::MODE_SHIFT) && ctrl_q[`SC_RX_ENABLE] &&
		!ctrl_q[`SC_RX_DONE] && (tx_state_q == serial_port_pkg::TX_IDLE) && !wr_buf;
	assign sync_start = (wr_buf && (mode == serial_port_pkg::MODE_SHIFT)) || rx_sync_go;
	assign sync_rise = sync_act && half_tick && !sclk_q;
	assign sync_fall = sync_act && half_tick && sclk_q;
	assign sync_end = sync_act && half_tick && (half_q == `SYNC_LAST_HALF);

	// Sixteen half periods make eight clock pulses; idles high
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sclk_q <= 1'b1;
			half_q <= 4'h0;
		end
		else if (sync_start)
		begin
			sclk_q <= 1'b0;
			half_q <= 4'h0;
		end
		else if (sync_act && half_tick)
		begin
			sclk_q <= ~sclk_q | sync_end;
			half_q <= half_q + 4'h1;
		end
		else if (!sync_act)
			sclk_q <= 1'b1;
	end

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	// RULE19 - nine-bit frames longer
	assign tx_last = (mode == serial_port_pkg::MODE_ASYNC8) ? `TX_LAST_8BIT : `TX_LAST_9BIT;
	assign tx_done = !wr_buf && (
		((tx_state_q == serial_port_pkg::TX_ASYNC) && tx_tick &&
		(tx_ovs_q == `OVS_LAST) && (tx_bit_q == tx_last)) ||
		((tx_state_q == serial_port_pkg::TX_SYNC) && sync_end));

	// A buffer write always restarts, even over a running frame
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_state_q <= serial_port_pkg::TX_IDLE;
			tx_frame_q <= `IDLE_FRAME;
			tx_ovs_q <= 4'h0;
			tx_bit_q <= 4'h0;
		end
		else if (wr_buf)
		begin
			tx_ovs_q <= 4'h0;
			tx_bit_q <= 4'h0;
			// RULE16 - write starts transmit
			if (mode == serial_port_pkg::MODE_SHIFT)
			begin
				tx_state_q <= serial_port_pkg::TX_SYNC;
				tx_frame_q <= {3'h7, wbyte};
			end
			else
			begin
				tx_state_q <= serial_port_pkg::TX_ASYNC;
				// RULE13 - send written ninth
				// RULE18 - start, data, stop
				tx_frame_q <= {1'b1,
					(mode == serial_port_pkg::MODE_ASYNC8) | ctrl_q[`SC_TX_NINTH],
					wbyte, 1'b0};
			end
		end
		else
		begin
			case (tx_state_q)
				serial_port_pkg::TX_IDLE:
					tx_frame_q <= `IDLE_FRAME;
				// One bit every sixteen ticks
				serial_port_pkg::TX_ASYNC:
					if (tx_tick)
					begin
						if (tx_ovs_q == `OVS_LAST)
						begin
							tx_ovs_q <= 4'h0;
							tx_frame_q <= {1'b1, tx_frame_q[10:1]};
							if (tx_bit_q == tx_last)
								tx_state_q <= serial_port_pkg::TX_IDLE;
							else
								tx_bit_q <= tx_bit_q + 4'h1;
						end
						else
							tx_ovs_q <= tx_ovs_q + 4'h1;
					end
				// RULE4 - shift on falling clock
				serial_port_pkg::TX_SYNC:
					if (sync_end)
						tx_state_q <= serial_port_pkg::TX_IDLE;
					else if (sync_fall)
						tx_frame_q <= {1'b1, tx_frame_q[10:1]};
				default:
					tx_state_q <= serial_port_pkg::TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	// Inputs arrive synchronous, so one flop suffices for the edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rx_prev_q <= 1'b1;
		else
			rx_prev_q <= serial_data_pin_in;
	end

	// RULE22 - start edge detect
	assign rx_fall = rx_prev_q & ~serial_data_pin_in;
	assign rx_last = (mode == serial_port_pkg::MODE_ASYNC8) ? `RX_LAST_8BIT : `RX_LAST_9BIT;
	assign rx_sample = (rx_state_q == serial_port_pkg::RX_DATA) && rx_tick &&
		(rx_ovs_q == `OVS_LAST);
	// In mode 1 the stop bit sits at the ninth position
	assign rx_ninth_val = (rx_bit_q == `RX_NINTH_IDX) ? serial_data_pin_in : rx_ninth_q;
	assign rx_load_async = rx_sample && (rx_bit_q == rx_last);
	// RULE14 - multiprocessor filter
	// RULE2 - unread character kept
	assign rx_load = ctrl_q[`SC_RX_ENABLE] && !ctrl_q[`SC_RX_DONE] && ((rx_load_async &&
		(!ctrl_q[`SC_MULTIPROC] || rx_ninth_val)) ||
		((rx_state_q == serial_port_pkg::RX_SYNC) && sync_end && !wr_buf));

	// RULE1 - independent receive engine
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_state_q <= serial_port_pkg::RX_IDLE;
			rx_shift_q <= `RESET_BYTE;
			rx_ninth_q <= 1'b0;
			rx_ovs_q <= 4'h0;
			rx_bit_q <= 4'h0;
		end
		// RULE21 - enable gates reception
		else if (!ctrl_q[`SC_RX_ENABLE])
			rx_state_q <= serial_port_pkg::RX_IDLE;
		else
		begin
			case (rx_state_q)
				serial_port_pkg::RX_IDLE:
					// RULE5 - mode 0 receive start
					if (rx_sync_go)
						rx_state_q <= serial_port_pkg::RX_SYNC;
					else if ((mode != serial_port_pkg::MODE_SHIFT) && rx_fall)
					begin
						rx_state_q <= serial_port_pkg::RX_START;
						rx_ovs_q <= 4'h0;
					end
				// RULE22 - confirm at midbit
				serial_port_pkg::RX_START:
					if (rx_tick)
					begin
						if (rx_ovs_q != `OVS_MID)
							rx_ovs_q <= rx_ovs_q + 4'h1;
						else if (serial_data_pin_in)
							rx_state_q <= serial_port_pkg::RX_IDLE;
						else
						begin
							rx_state_q <= serial_port_pkg::RX_DATA;
							rx_ovs_q <= 4'h0;
							rx_bit_q <= 4'h0;
						end
					end
				// RULE22 - sample bit centres
				serial_port_pkg::RX_DATA:
					if (rx_tick)
					begin
						rx_ovs_q <= rx_ovs_q + 4'h1;
						if (rx_sample)
						begin
							if (rx_bit_q < `RX_NINTH_IDX)
								rx_shift_q <= {serial_data_pin_in, rx_shift_q[7:1]};
							else if (rx_bit_q == `RX_NINTH_IDX)
								rx_ninth_q <= serial_data_pin_in;
							if (rx_bit_q == rx_last)
								rx_state_q <= serial_port_pkg::RX_IDLE;
							else
								rx_bit_q <= rx_bit_q + 4'h1;
						end
					end
				// RULE4 - sample on rising clock
				serial_port_pkg::RX_SYNC:
					if (wr_buf || sync_end)
						rx_state_q <= serial_port_pkg::RX_IDLE;
					else if (sync_rise)
						rx_shift_q <= {serial_data_pin_in, rx_shift_q[7:1]};
				default:
					rx_state_q <= serial_port_pkg::RX_IDLE;
			endcase
		end
	end

	// Holding register loads only on an accepted character
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rx_hold_q <= `RESET_BYTE;
		else if (rx_load)
			rx_hold_q <= rx_shift_q;
	end

	// ------------------------------------------------------------
	// Pins and interrupt
	// ------------------------------------------------------------
	// Pins lag the engines by one clock, far inside a bit time
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_pin_q <= 1'b1;
			data_out_q <= 1'b1;
			data_oe_n_q <= 1'b1;
		end
		else
		begin
			// RULE4 - shift clock on out pin
			out_pin_q <= (mode == serial_port_pkg::MODE_SHIFT) ? sclk_q : tx_frame_q[0];
			data_out_q <= tx_frame_q[0];
			data_oe_n_q <= (tx_state_q != serial_port_pkg::TX_SYNC);
		end
	end

	// RULE10 - flags gated by enable
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_q <= 1'b0;
			pri_q <= 1'b0;
		end
		else
		begin
			irq_q <= (ctrl_q[`SC_RX_DONE] | ctrl_q[`SC_TX_DONE]) & ie_q[`IE_SERIAL];
			pri_q <= ip_q[`IP_SERIAL];
		end
	end

	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign serial_data_pin_out = data_out_q;
	assign serial_data_pin_oe_n = data_oe_n_q;
	assign serial_out_pin = out_pin_q;
	assign serial_irq = irq_q;
	assign serial_irq_priority = pri_q;

endmodule : classic_serial_port_zero

// ==== design/serial_port_defs.svh ====
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// ------------------------------------------------------------
// Register indices (word address on the bus)
// ------------------------------------------------------------
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_SERIAL_CONTROL 8'h98
`define ADDR_SERIAL_BUFFER 8'h99
`define ADDR_IRQ_ENABLE 8'hA8
`define ADDR_IRQ_PRIORITY 8'hB8

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SC_RX_DONE 0
`define SC_TX_DONE 1
`define SC_RX_NINTH 2
`define SC_TX_NINTH 3
`define SC_RX_ENABLE 4
`define SC_MULTIPROC 5
`define SC_MODE_LOW 6
`define SC_MODE_HIGH 7
`define PC_BAUD_DOUBLER 7
`define IE_SERIAL 4
`define IP_SERIAL 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000
`define IDLE_FRAME 11'h7FF

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define TX_LAST_8BIT 4'h9
`define TX_LAST_9BIT 4'hA
`define RX_LAST_8BIT 4'h8
`define RX_LAST_9BIT 4'h9
`define RX_NINTH_IDX 4'h8
`define SYNC_LAST_HALF 4'hF
`define SHIFT_HALF_LAST 3'h5
`define FIXED_LIMIT_SLOW 2'h3
`define FIXED_LIMIT_FAST 2'h1

`endif

// ==== design/serial_port_pkg.sv ====
package serial_port_pkg;

	// Operating modes, from the two mode select bits
	typedef enum logic [1:0]
	{
		MODE_SHIFT = 2'h0,
		MODE_ASYNC8 = 2'h1,
		MODE_FIXED9 = 2'h2,
		MODE_VAR9 = 2'h3
	} mode_t;

	// Transmit engine states
	typedef enum logic [2:0]
	{
		TX_IDLE = 3'h1,
		TX_ASYNC = 3'h2,
		TX_SYNC = 3'h4
	} tx_state_t;

	// Receive engine states
	typedef enum logic [3:0]
	{
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_SYNC = 4'h8
	} rx_state_t;

endpackage : serial_port_pkg

// ==== design/serial_rate_gen.sv ====
`timescale 1ns/100ps
`include "serial_port_defs.svh"

module serial_rate_gen
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Configuration
	input wire serial_port_pkg::mode_t mode,
	input wire logic baud_doubler,
	input wire logic tx_from_t2,
	input wire logic rx_from_t2,
	// Timer overflow pulses
	input wire logic t1_overflow,
	input wire logic t2_overflow,
	// Shift clock restart
	input wire logic shift_restart,
	// Ticks
	output logic tx_tick,
	output logic rx_tick,
	output logic shift_half_tick
);

	// ------------------------------------------------------------
	// Timer 1 halving
	// ------------------------------------------------------------
	logic t1_half_q; // Alternates on each timer 1 overflow
	logic t1_tick; // Sixteen-times tick from timer 1
	logic [1:0] fixed_cnt_q; // Prescaler for the fixed rate mode
	logic [1:0] fixed_limit; // Prescaler end value
	logic fixed_tick; // Sixteen-times tick at fixed rate
	logic [2:0] shift_cnt_q; // Half period counter for mode 0

	// Halving gives the /32 rate without doubling
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			t1_half_q <= 1'b0;
		else if (t1_overflow)
			t1_half_q <= ~t1_half_q;
	end

	// RULE6 - timer 1 halved
	assign t1_tick = t1_overflow & (baud_doubler | t1_half_q);

	// ------------------------------------------------------------
	// Fixed rate prescaler
	// ------------------------------------------------------------
	// RULE20 - fixed rate divide
	assign fixed_limit = baud_doubler ? `FIXED_LIMIT_FAST : `FIXED_LIMIT_SLOW;
	assign fixed_tick = (fixed_cnt_q == fixed_limit);

	// Free running, so a tick lands every 2 or 4 clocks
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			fixed_cnt_q <= 2'h0;
		else if (fixed_tick)
			fixed_cnt_q <= 2'h0;
		else
			fixed_cnt_q <= fixed_cnt_q + 2'h1;
	end

	// RULE7 - variable rate source
	assign tx_tick = (mode == serial_port_pkg::MODE_FIXED9) ? fixed_tick :
		(tx_from_t2 ? t2_overflow : t1_tick);
	assign rx_tick = (mode == serial_port_pkg::MODE_FIXED9) ? fixed_tick :
		(rx_from_t2 ? t2_overflow : t1_tick);

	// ------------------------------------------------------------
	// Mode 0 half period
	// ------------------------------------------------------------
	// Restart aligns the first half period with the transfer start
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			shift_cnt_q <= 3'h0;
		else if (shift_restart || shift_half_tick)
			shift_cnt_q <= 3'h0;
		else
			shift_cnt_q <= shift_cnt_q + 3'h1;
	end

	// RULE4 - twelve clocks per bit
	assign shift_half_tick = (shift_cnt_q == `SHIFT_HALF_LAST);

endmodule : serial_rate_gen

// ==== dv/serial_line_partner.sv ====
`timescale 1ns/100ps

// ----------------------------------------
// Far-end serial device, asynchronous only
// ----------------------------------------
module serial_line_partner
(
	// Clock
	input wire logic clk,
	// Line from the port transmitter
	input wire logic tx_line,
	// Line into the port receiver
	output logic rx_line
);
	// Bit period in clocks, frame length in bits
	int bit_clks = 32;
	int nbits = 11;
	// Last captured frame, start bit at index 0
	logic [10:0] cap;
	// Frames captured so far
	int caps = 0;

	// Idle line is marking
	initial rx_line = 1'h1;

	task automatic send(input logic [10:0] f);
		for (int i = 0; i < nbits; i++)
		begin
			rx_line <= f[i];
			repeat (bit_clks) @(posedge clk);
		end
		rx_line <= 1'h1;
	endtask : send

	// sample each bit at its centre
	always
	begin
		@(negedge tx_line);
		cap = 11'h000;
		repeat (bit_clks / 2) @(posedge clk);
		for (int i = 0; i < nbits; i++)
		begin
			cap[i] = tx_line;
			if (i < nbits - 1)
				repeat (bit_clks) @(posedge clk);
		end
		caps++;
	end
endmodule : serial_line_partner

// ==== dv/classic_serial_port_zero_properties.sv ====
`timescale 1ns/100ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module serial_port_checker
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register bus
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Pins
	input wire logic serial_data_pin_oe_n,
	input wire logic serial_out_pin,
	input wire logic serial_irq,
	input wire logic serial_irq_priority
);
	// Shadows of enable, priority and mode bits
	logic ie_q;
	logic ip_q;
	logic [1:0] mode_q;
	logic wr_done;
	assign wr_done = write && !waitrequest && byteenable[0];

	// Follow completed writes, as the port does
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ie_q <= 1'h0;
			ip_q <= 1'h0;
			mode_q <= 2'h0;
		end
		else if (wr_done)
		begin
			if (address == 8'hA8) ie_q <= writedata[4];
			if (address == 8'hB8) ip_q <= writedata[4];
			if (address == 8'h98) mode_q <= writedata[7:6];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("access not answered");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	a_read_unmapped: assert property (read && !waitrequest &&
		!(address inside {8'h87, 8'h98, 8'h99, 8'hA8, 8'hB8}) |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_tx_start: assert property (wr_done && address == 8'h99 && mode_q != 2'h0
		|-> ##[1:80] !serial_out_pin) else $error("no start bit");
	a_async_bit_len: assert property ($fell(serial_out_pin) && mode_q != 2'h0
		&& $stable(mode_q) |-> !serial_out_pin [*8]) else $error("short low bit");
	a_shift_high: assert property ($rose(serial_out_pin) && mode_q == 2'h0
		|-> serial_out_pin [*6]) else $error("shift clock high phase wrong");
	a_oe_async: assert property (mode_q != 2'h0 && $past(mode_q) != 2'h0
		|-> serial_data_pin_oe_n) else $error("data pin driven in async mode");
	a_irq_masked: assert property (!ie_q && !$past(ie_q) |-> !serial_irq)
		else $error("interrupt while disabled");
	a_prio_copy: assert property (ip_q == $past(ip_q) && ip_q == $past(ip_q, 2)
		|-> serial_irq_priority == ip_q) else $error("priority not copied");

	// Main scenarios reached
	c_buffer_write: cover property (wr_done && address == 8'h99);
	c_irq_cancel: cover property ($fell(serial_irq));
	c_shift_drive: cover property (!serial_data_pin_oe_n);
endmodule : serial_port_checker

bind classic_serial_port_zero serial_port_checker serial_port_checker_inst (.clk, .nrst,
	.address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
	.serial_data_pin_oe_n, .serial_out_pin, .serial_irq, .serial_irq_priority);

// ==== dv/test_classic_serial_port_zero.sv ====
`timescale 1ns/100ps

// ----------------------------------------
// Testbench
// ----------------------------------------
module test_classic_serial_port_zero;
	// Bus and pin signals
	logic clk, nrst, read, write, waitrequest;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata;
	logic t1_overflow, t2_overflow, tx_rate_from_t2, rx_rate_from_t2;
	logic data_out, data_oe_n, serial_out_pin, serial_irq, serial_irq_priority;
	logic rx_line, data_wire;
	// Counters and scratch
	int error_cnt = 0;
	int samples_checked = 0;
	int c0;
	realtime t0;
	logic [7:0] rd, tx_b, rx_b, hold, ip;
	logic [1:0] m;
	logic d, t, n9;
	logic [11:0] rows [7] = '{12'h200, 12'h210, 12'h100, 12'h110, 12'h101, 12'h300, 12'h311};
	logic [7:0] ctl [4] = '{8'hB0, 8'hB0, 8'hB1, 8'h80};
	logic [3:0] nin = 4'hE;
	logic [3:0] acc = 4'h2;
	logic [7:0] regs [6] = '{8'h87, 8'h98, 8'h99, 8'hA8, 8'hB8, 8'h50};

	// Shared data pin: partner drives while the port lets go
	assign data_wire = data_oe_n ? rx_line : data_out;

	classic_serial_port_zero classic_serial_port_zero_inst (.clk, .nrst, .address, .read,
		.write, .byteenable, .writedata, .readdata, .waitrequest, .t1_overflow,
		.t2_overflow, .tx_rate_from_t2, .rx_rate_from_t2, .serial_data_pin_in(data_wire),
		.serial_data_pin_out(data_out), .serial_data_pin_oe_n(data_oe_n),
		.serial_out_pin, .serial_irq, .serial_irq_priority);
	serial_line_partner serial_line_partner_inst (.clk, .tx_line(serial_out_pin), .rx_line);

	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	// Both timers overflow every second clock, out of phase
	always @(posedge clk)
	begin
		t1_overflow <= ~t1_overflow;
		t2_overflow <= t1_overflow;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		address <= a;
		writedata <= {24'h000000, v};
		read <= ~w;
		write <= w;
		do @(posedge clk); while (waitrequest !== 1'h0);
		rd = readdata[7:0];
		read <= 1'h0;
		write <= 1'h0;
	endtask : bus

	// Poll control until a flag shows
	task automatic wait_ctrl(input int b);
		rd = 8'h00;
		for (int i = 0; i < 400 && rd[b] !== 1'h1; i++) bus(1'h0, 8'h98, 8'h00);
	endtask : wait_ctrl

	task automatic test_done;
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// Watchdog, well beyond the expected run
	initial
	begin
		#200000;
		error_cnt++;
		test_done();
	end

	initial
	begin
		{nrst, read, write, address, writedata, t1_overflow, t2_overflow} = '0;
		{tx_rate_from_t2, rx_rate_from_t2} = 2'h0;
		byteenable = 4'h1;
		void'($urandom(36361));
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		// Reset values, unmapped place included
		foreach (regs[i])
		begin
			bus(1'h0, regs[i], 8'h00);
			check(rd, 8'h00, "reset value");
		end
		ip = $urandom;
		bus(1'h1, 8'hB8, ip);
		bus(1'h1, 8'hA8, 8'h10);
		bus(1'h0, 8'hB8, 8'h00);
		check(rd, ip, "priority reg");
		check(serial_irq_priority, ip[4], "priority pin");
		// Modes 1 to 3, each doubler and timer choice, both directions at once
		foreach (rows[r])
		begin
			m = rows[r][9:8];
			d = rows[r][4];
			t = rows[r][0];
			serial_line_partner_inst.bit_clks = (d || (t && m != 2'h2)) ? 32 : 64;
			serial_line_partner_inst.nbits = (m == 2'h1) ? 10 : 11;
			tx_b = $urandom;
			rx_b = $urandom;
			n9 = $urandom;
			tx_rate_from_t2 <= t;
			rx_rate_from_t2 <= t;
			bus(1'h1, 8'h87, {d, 7'h00});
			bus(1'h1, 8'h98, {m, 2'h1, n9, 3'h0});
			c0 = serial_line_partner_inst.caps;
			fork
				serial_line_partner_inst.send(m == 2'h1 ? {2'h3, rx_b, 1'h0} : {1'h1, ~n9, rx_b, 1'h0});
				bus(1'h1, 8'h99, tx_b);
			join
			wait_ctrl(1);
			check(serial_line_partner_inst.caps - c0, 1, "frames");
			check(serial_line_partner_inst.cap, m == 2'h1 ? {2'h1, tx_b, 1'h0}
				: {1'h1, n9, tx_b, 1'h0}, "tx frame");
			check(rd, {m, 2'h1, n9, m == 2'h1 ? 1'h1 : ~n9, 2'h3}, "control");
			bus(1'h0, 8'h99, 8'h00);
			check(rd, rx_b, "rx byte");
			check(serial_irq, 1'h1, "irq");
		end
		// Address filter, unread holding, disabled receiver
		hold = rx_b;
		serial_line_partner_inst.bit_clks = 32;
		serial_line_partner_inst.nbits = 11;
		foreach (ctl[i])
		begin
			bus(1'h1, 8'h98, ctl[i]);
			rx_b = $urandom;
			serial_line_partner_inst.send({1'h1, nin[i], rx_b, 1'h0});
			bus(1'h0, 8'h98, 8'h00);
			check(rd[0], ctl[i][0] | acc[i], "rx flag");
			if (acc[i])
				hold = rx_b;
			bus(1'h0, 8'h99, 8'h00);
			check(rd, hold, "holding");
			check(serial_irq, ctl[i][0] | acc[i], "irq follows flag");
		end
		// Shift register transmit: eight bits, LSB first, clk/12
		bus(1'h1, 8'h98, 8'h00);
		tx_b = $urandom;
		bus(1'h1, 8'h99, tx_b);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge serial_out_pin);
			if (i == 0)
				t0 = $realtime;
			check(data_wire, tx_b[i], "shift bit");
		end
		check(int'(($realtime - t0) / 4.0), 84, "shift rate");
		wait_ctrl(1);
		check(rd[1], 1'h1, "shift done");
		test_done();
	end
endmodule : test_classic_serial_port_zero
